/* File: shared/mms_pkg.sv */
// Package for the memory subsystem front end: address map, sizes and boot stages.
// Assumes a single 50 MHz system clock and synchronous active-high reset.
package mms_pkg;

  // Address map.
  localparam logic [31:0] ROM_BASE      = 32'h0000_0000;
  localparam logic [31:0] ROM_LAST      = 32'h0000_FFFF;
  localparam logic [31:0] SRAM_BASE     = 32'h0800_0000;
  localparam logic [31:0] SRAM_LAST     = 32'h0801_FFFF;
  localparam logic [31:0] AFL_BASE      = 32'h1000_0000;
  localparam logic [31:0] AFL_LAST      = 32'h1003_FFFF;
  localparam logic [31:0] SFL_BASE      = 32'h1600_0000;
  localparam logic [31:0] SFL_LAST      = 32'h1600_7FFF;
  localparam logic [31:0] CODE_LAST     = 32'h1FFF_FFFF;
  localparam logic [31:0] DATA_BASE     = 32'h2000_0000;
  localparam logic [31:0] DATA_LAST     = 32'h3FFF_FFFF;
  localparam logic [31:0] PERIPH_BASE   = 32'h4000_0000;
  localparam logic [31:0] PERIPH_LAST   = 32'h5FFF_FFFF;
  localparam logic [31:0] EXT_BASE      = 32'h6000_0000;
  localparam logic [31:0] EXT_LAST      = 32'h9FFF_FFFF;
  localparam logic [31:0] VECTOR_BASE   = 32'h0000_0000;

  // Sizes and geometry.
  localparam int unsigned AFL_SECTOR_BYTES = 131072;
  localparam int unsigned AFL_SECTORS      = 2;
  localparam int unsigned ROW_BYTES        = 512;
  localparam int unsigned ROW_SHIFT        = 9;
  localparam int unsigned LINE_BYTES       = 16;
  localparam int unsigned LINE_SHIFT       = 4;
  localparam int unsigned CACHE_BYTES      = 8192;
  localparam int unsigned CACHE_WAYS       = 4;
  localparam int unsigned CACHE_SETS       = CACHE_BYTES / (CACHE_WAYS * LINE_BYTES);
  localparam int unsigned SET_BITS         = 7;
  localparam int unsigned TAG_BITS         = 32 - SET_BITS - LINE_SHIFT;
  localparam int unsigned SRAM_BLOCK_BYTES = 32768;
  localparam int unsigned SRAM_BLOCKS      = 4;
  localparam int unsigned FUSE_BITS        = 1024;
  localparam int unsigned FUSE_SYS_BITS    = 512;
  localparam int unsigned FUSE_IDX_BITS    = 10;
  localparam logic [2:0]  BOOT_CONTEXT     = 3'h0;

  // Masters on the shared map.
  typedef enum logic [1:0] {
    MMS_MAIN_CORE,
    MMS_SECONDARY_CORE,
    MMS_DEBUG_PORT,
    MMS_DMA
  } mms_master_t;

  // Decoded targets.
  typedef enum logic [2:0] {
    MMS_T_NONE,
    MMS_T_ROM,
    MMS_T_SRAM,
    MMS_T_AFL,
    MMS_T_SFL,
    MMS_T_PERIPH,
    MMS_T_EXT
  } mms_target_t;

  // Boot hand-off stages.
  typedef enum logic [3:0] {
    MMS_B_CHECK_FBOOT,
    MMS_B_TRIM,
    MMS_B_PROT,
    MMS_B_LIFECYCLE,
    MMS_B_SYSCALL_EN,
    MMS_B_DEBUG_CFG,
    MMS_B_VALIDATE,
    MMS_B_USER,
    MMS_B_SAFE
  } mms_boot_t;

  // One bus request from any master.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    mms_master_t master;
    logic [2:0]  prot_ctx;
    logic [31:0] addr;
  } mms_req_t;

  // Decoder answer for one request.
  typedef struct packed {
    logic        done;
    logic        error;
    mms_target_t target;
    logic [31:0] offset;
  } mms_resp_t;

  // Flash controller commands.
  typedef struct packed {
    logic        row_write;
    logic        sfl_sel;
    logic [31:0] row_addr;
  } mms_flash_cmd_t;

endpackage

/* File: src/mms_mem_front.sv */
// Memory subsystem front end: shared address decoder, execute permissions,
// flash access rules, per-core line caches tags, SRAM block control, fuse array
// and the boot hand-off sequencer.
// Assumes requests are synchronous to clk_sys; storage arrays sit outside.
`timescale 1ns/100ps

module mms_mem_front
  import mms_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // Shared bus request and decoded answer
  input  wire mms_req_t                 req,
  output mms_resp_t                     resp,
  // Flash side
  input  wire logic                     low_voltage_power_mode,
  input  wire logic                     lifecycle_secure,
  output mms_flash_cmd_t                flash_cmd,
  output logic [31:0]                   flash_line_addr,
  output logic                          flash_line_rd,
  input  wire logic [127:0]             flash_line_data,
  output logic [127:0]                  read_line,
  // Cache lookup per core
  output logic [1:0]                    cache_hit,
  // SRAM block control
  input  wire logic [SRAM_BLOCKS-1:0]   sram_power_en,
  input  wire logic [SRAM_BLOCKS-1:0]   sram_retain_en,
  input  wire logic                     deep_sleep,
  input  wire logic                     hibernate_entry,
  output logic [SRAM_BLOCKS-1:0]        sram_block_on,
  output logic [SRAM_BLOCKS-1:0]        sram_contents_valid,
  // System function requests
  input  wire logic [2:0]               sysfn_req,
  output logic                          secondary_nmi,
  // Fuse programming and read
  input  wire logic                     fuse_prog,
  input  wire logic [FUSE_IDX_BITS-1:0] fuse_index,
  input  wire logic                     fuse_custom_only,
  output logic [FUSE_BITS-1:0]          fuse_bits,
  // Boot sequencing
  input  wire logic                     boot_step_done,
  input  wire logic                     boot_check_ok,
  input  wire logic                     user_valid,
  output mms_boot_t                     boot_stage,
  output logic                          syscalls_enabled,
  output logic                          debug_configured,
  output logic                          user_launched,
  output logic                          safe_state,
  output logic [31:0]                   vector_base
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [TAG_BITS-1:0] line_tag(input logic [31:0] a);
    line_tag = a[31:SET_BITS+LINE_SHIFT];
  endfunction

  function automatic logic [SET_BITS-1:0] line_set(input logic [31:0] a);
    line_set = a[SET_BITS+LINE_SHIFT-1:LINE_SHIFT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and permissions.

  mms_target_t next_target;
  logic [31:0] next_offset;
  logic        next_error;
  logic        is_flash_write;

  always_comb begin
    next_target = MMS_T_NONE;
    next_offset = 32'h0000_0000;
    next_error  = 1'b0;
    if (in_range(req.addr, ROM_BASE, ROM_LAST)) begin
      next_target = MMS_T_ROM;
      next_offset = req.addr - ROM_BASE;
      // Only the secondary core in the boot context may fetch from ROM.
      if (req.fetch && !(req.master == MMS_SECONDARY_CORE && req.prot_ctx == BOOT_CONTEXT)) begin
        next_error = 1'b1;
      end
      if (req.write) begin
        next_error = 1'b1;
      end
    end else if (in_range(req.addr, SRAM_BASE, SRAM_LAST)) begin
      next_target = MMS_T_SRAM;
      next_offset = req.addr - SRAM_BASE;
      if (!sram_block_on[next_offset[16:15]]) begin
        next_error = 1'b1;
      end
    end else if (in_range(req.addr, AFL_BASE, AFL_LAST)) begin
      next_target = MMS_T_AFL;
      next_offset = req.addr - AFL_BASE;
    end else if (in_range(req.addr, SFL_BASE, SFL_LAST)) begin
      next_target = MMS_T_SFL;
      next_offset = req.addr - SFL_BASE;
      if (req.write && lifecycle_secure) begin
        next_error = 1'b1;
      end
    end else if (in_range(req.addr, DATA_BASE, DATA_LAST)) begin
      next_error = 1'b1;
    end else if (in_range(req.addr, PERIPH_BASE, PERIPH_LAST)) begin
      next_target = MMS_T_PERIPH;
      next_offset = req.addr - PERIPH_BASE;
      if (req.fetch) begin
        next_error = 1'b1;
      end
    end else if (in_range(req.addr, EXT_BASE, EXT_LAST)) begin
      next_target = MMS_T_EXT;
      next_offset = req.addr - EXT_BASE;
    end else if (req.addr <= CODE_LAST) begin
      // Holes in the code region are decoded but unpopulated.
      next_error = 1'b1;
    end else begin
      next_error = 1'b1;
    end
    if ((next_target == MMS_T_AFL) && req.write && low_voltage_power_mode) begin
      next_error = 1'b1;
    end
    if (next_error) begin
      next_target = MMS_T_NONE;
    end
  end

  assign is_flash_write = req.valid && req.write && !next_error &&
                          ((next_target == MMS_T_AFL) || (next_target == MMS_T_SFL));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.done   <= req.valid;
      resp.error  <= req.valid && next_error;
      resp.target <= next_target;
      resp.offset <= next_offset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash row writes and wide line reads.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.row_write <= is_flash_write;
      flash_cmd.sfl_sel   <= next_target == MMS_T_SFL;
      flash_cmd.row_addr  <= {next_offset[31:ROW_SHIFT], {ROW_SHIFT{1'b0}}};
    end
  end

  logic flash_read;
  logic core_sel;
  logic miss;

  assign flash_read = req.valid && !req.write && !next_error &&
                      ((next_target == MMS_T_AFL) || (next_target == MMS_T_SFL));
  assign core_sel   = req.master == MMS_SECONDARY_CORE;

  ////////////////////////////////////////////////////////////////////////////
  // Per-core four-way tag stores with round-robin replacement.

  logic [TAG_BITS-1:0] tag_mem   [2][CACHE_WAYS][CACHE_SETS];
  logic                tag_valid [2][CACHE_WAYS][CACHE_SETS];
  logic [1:0]          victim    [2];
  logic [CACHE_WAYS-1:0] way_hit;

  always_comb begin
    for (int w = 0; w < CACHE_WAYS; w++) begin
      way_hit[w] = tag_valid[core_sel][w][line_set(req.addr)] &&
                   (tag_mem[core_sel][w][line_set(req.addr)] == line_tag(req.addr));
    end
  end

  logic core_owner;

  // Only the two cores own a cache; DMA and debug reads bypass it and always go to the array,
  // otherwise a tag left by the main core would starve them of their line.
  assign core_owner = (req.master == MMS_MAIN_CORE) || core_sel;
  assign miss       = flash_read && !(core_owner && (|way_hit));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        victim[c] <= 2'h0;
        for (int w = 0; w < CACHE_WAYS; w++) begin
          for (int s = 0; s < CACHE_SETS; s++) begin
            tag_valid[c][w][s] <= 1'b0;
            tag_mem[c][w][s]   <= '0;
          end
        end
      end
    end else if (is_flash_write) begin
      // A row write makes every cached copy suspect, so both caches flush.
      for (int c = 0; c < 2; c++) begin
        for (int w = 0; w < CACHE_WAYS; w++) begin
          for (int s = 0; s < CACHE_SETS; s++) begin
            tag_valid[c][w][s] <= 1'b0;
          end
        end
      end
    end else if (miss && (req.master == MMS_MAIN_CORE || core_sel)) begin
      tag_valid[core_sel][victim[core_sel]][line_set(req.addr)] <= 1'b1;
      tag_mem[core_sel][victim[core_sel]][line_set(req.addr)]   <= line_tag(req.addr);
      victim[core_sel] <= victim[core_sel] + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cache_hit       <= 2'h0;
      flash_line_rd   <= 1'b0;
      flash_line_addr <= 32'h0000_0000;
      read_line       <= '0;
    end else begin
      cache_hit[0]    <= flash_read && req.master == MMS_MAIN_CORE && (|way_hit);
      cache_hit[1]    <= flash_read && core_sel && (|way_hit);
      flash_line_rd   <= miss;
      flash_line_addr <= {next_offset[31:LINE_SHIFT], {LINE_SHIFT{1'b0}}};
      read_line       <= flash_line_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SRAM block power and retention.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sram_block_on       <= {SRAM_BLOCKS{1'b1}};
      sram_contents_valid <= {SRAM_BLOCKS{1'b0}};
    end else if (hibernate_entry) begin
      sram_block_on       <= {SRAM_BLOCKS{1'b0}};
      sram_contents_valid <= {SRAM_BLOCKS{1'b0}};
    end else if (deep_sleep) begin
      // Unretained blocks lose their contents across deep sleep.
      sram_block_on       <= sram_power_en & sram_retain_en;
      sram_contents_valid <= sram_contents_valid & sram_retain_en;
    end else begin
      sram_block_on       <= sram_power_en;
      sram_contents_valid <= sram_contents_valid | sram_power_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System function requests and fuses.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      secondary_nmi <= 1'b0;
    end else begin
      secondary_nmi <= |sysfn_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fuse_bits <= '0;
    end else if (fuse_prog && (!fuse_custom_only ||
                               fuse_index >= FUSE_IDX_BITS'(FUSE_SYS_BITS))) begin
      fuse_bits[fuse_index] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot hand-off sequence.

  mms_boot_t next_stage;

  always_comb begin
    next_stage = boot_stage;
    case (boot_stage)
      MMS_B_CHECK_FBOOT: begin
        if (boot_step_done) begin
          next_stage = boot_check_ok ? MMS_B_TRIM : MMS_B_SAFE;
        end
      end
      MMS_B_TRIM:       if (boot_step_done) next_stage = MMS_B_PROT;
      MMS_B_PROT:       if (boot_step_done) next_stage = MMS_B_LIFECYCLE;
      MMS_B_LIFECYCLE:  if (boot_step_done) next_stage = MMS_B_SYSCALL_EN;
      MMS_B_SYSCALL_EN: if (boot_step_done) next_stage = MMS_B_DEBUG_CFG;
      MMS_B_DEBUG_CFG:  if (boot_step_done) next_stage = MMS_B_VALIDATE;
      MMS_B_VALIDATE: begin
        if (boot_step_done) begin
          next_stage = user_valid ? MMS_B_USER : MMS_B_SAFE;
        end
      end
      MMS_B_USER:       next_stage = MMS_B_USER;
      MMS_B_SAFE:       next_stage = MMS_B_SAFE;
      default:          next_stage = MMS_B_SAFE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boot_stage       <= MMS_B_CHECK_FBOOT;
      syscalls_enabled <= 1'b0;
      debug_configured <= 1'b0;
      user_launched    <= 1'b0;
      safe_state       <= 1'b0;
      vector_base      <= VECTOR_BASE;
    end else begin
      boot_stage <= next_stage;
      if (boot_stage == MMS_B_SYSCALL_EN && boot_step_done) begin
        syscalls_enabled <= 1'b1;
      end
      if (boot_stage == MMS_B_DEBUG_CFG && boot_step_done) begin
        debug_configured <= 1'b1;
      end
      user_launched <= next_stage == MMS_B_USER;
      safe_state    <= next_stage == MMS_B_SAFE;
      vector_base   <= VECTOR_BASE;
    end
  end

endmodule

/* File: sim/mms_mem_front_props.sv */
// Checker for the memory front end: decode, execute permission, flash and fuse behaviour.
// Assumes it is bound to mms_mem_front and shares its single clock and reset.
`timescale 1ns/100ps
module mms_mem_front_props
  import mms_pkg::*;
(
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst,
  // Bus
  input wire mms_req_t               req,
  input wire mms_resp_t              resp,
  // Flash side
  input wire logic                   low_voltage_power_mode,
  input wire logic                   lifecycle_secure,
  input wire mms_flash_cmd_t         flash_cmd,
  input wire logic [31:0]            flash_line_addr,
  input wire logic                   flash_line_rd,
  // Misc
  input wire logic                   hibernate_entry,
  input wire logic [SRAM_BLOCKS-1:0] sram_contents_valid,
  input wire logic [2:0]             sysfn_req,
  input wire logic                   secondary_nmi,
  input wire logic [FUSE_BITS-1:0]   fuse_bits
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic in_rom, in_afl, in_sfl, in_dat, in_per, in_ext;
  assign in_rom = req.addr <= ROM_LAST;
  assign in_afl = req.addr >= AFL_BASE && req.addr <= AFL_LAST;
  assign in_sfl = req.addr >= SFL_BASE && req.addr <= SFL_LAST;
  assign in_dat = req.addr >= DATA_BASE && req.addr <= DATA_LAST;
  assign in_per = req.addr >= PERIPH_BASE && req.addr <= PERIPH_LAST;
  assign in_ext = req.addr >= EXT_BASE && req.addr <= EXT_LAST;

  ////////////////////////////////////////////////////////////////////////////////
  a_answer_next: assert property (req.valid |=> resp.done)
    else $error("no answer one cycle after a request");
  a_data_hole: assert property (req.valid && in_dat |=> resp.error)
    else $error("data region access was not refused");
  a_periph_nofetch: assert property (req.valid && req.fetch && in_per |=> resp.error)
    else $error("peripheral fetch was not refused");
  a_ext_fetch: assert property (req.valid && req.fetch && !req.write && in_ext
    |=> !resp.error && resp.target == MMS_T_EXT)
    else $error("external memory fetch was refused");
  a_rom_exec: assert property (req.valid && req.fetch && in_rom
    && !(req.master == MMS_SECONDARY_CORE && req.prot_ctx == BOOT_CONTEXT) |=> resp.error)
    else $error("boot rom fetch by wrong master or context");
  a_lv_nowrite: assert property (req.valid && req.write && in_afl && low_voltage_power_mode
    |=> resp.error && !flash_cmd.row_write)
    else $error("flash write started in low-voltage mode");
  a_sfl_locked: assert property (req.valid && req.write && in_sfl && lifecycle_secure
    |=> resp.error && !flash_cmd.row_write)
    else $error("supervisory flash changed while secure");
  a_row_whole: assert property (flash_cmd.row_write |-> flash_cmd.row_addr[8:0] == 9'h000)
    else $error("row write address not row aligned");
  a_line_wide: assert property (flash_line_rd |-> flash_line_addr[3:0] == 4'h0)
    else $error("flash line address not line aligned");
  a_nmi_follow: assert property (1'b1 |=> secondary_nmi == ($past(sysfn_req) != 3'h0))
    else $error("nmi does not follow system function requests");
  a_fuse_sticky: assert property (($past(fuse_bits) & ~fuse_bits) == '0)
    else $error("a programmed fuse went back to zero");
  a_hib_lost: assert property (hibernate_entry |=> sram_contents_valid == '0)
    else $error("sram kept contents over hibernate");
endmodule

bind mms_mem_front mms_mem_front_props u_props (.clk_sys(clk_sys), .rst(rst), .req(req),
  .resp(resp), .low_voltage_power_mode(low_voltage_power_mode),
  .lifecycle_secure(lifecycle_secure), .flash_cmd(flash_cmd),
  .flash_line_addr(flash_line_addr), .flash_line_rd(flash_line_rd),
  .hibernate_entry(hibernate_entry), .sram_contents_valid(sram_contents_valid),
  .sysfn_req(sysfn_req), .secondary_nmi(secondary_nmi), .fuse_bits(fuse_bits));

/* File: sim/mms_flash_model.sv */
// Flash array model: answers a 128-bit line read with the line address repeated.
// Assumes the front end registers its line address and read strobe.
`timescale 1ns/100ps
module mms_flash_model (
  // Line request
  input wire logic [31:0]   flash_line_addr,
  input wire logic          flash_line_rd,
  // Line data
  output logic [127:0]      flash_line_data
);
  // Outside a read the lines show the inverse so a stale sample never matches.
  assign flash_line_data = flash_line_rd ? {4{flash_line_addr}} : ~{4{flash_line_addr}};
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the memory front end.
// Assumes the bound checker and the flash array model sit beside the design.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb
  import mms_pkg::*;
;
  localparam mms_master_t MC = MMS_MAIN_CORE;
  localparam mms_master_t SC = MMS_SECONDARY_CORE;
  logic clk_sys = 1'b0, rst = 1'b1, lvm = 1'b0, sec = 1'b0, dsl = 1'b0, hib = 1'b0;
  logic fprg = 1'b0, fco = 1'b0, stp = 1'b0, ck_ok = 1'b1, uv = 1'b1;
  logic [3:0] pwr = 4'hF, ret = 4'hF;
  logic [2:0] sfn = 3'h0;
  logic [9:0] fidx = 10'h000;
  logic [127:0] fdat, rline;
  logic [FUSE_BITS-1:0] fuses, fexp = '0;
  logic [31:0] faddr, vbase;
  logic [3:0] s_on, s_val;
  logic [1:0] hit;
  logic frd, nmi, sys_en, dbg_en, launched, safe;
  mms_req_t req = '0;
  mms_resp_t resp;
  mms_flash_cmd_t fcmd;
  mms_boot_t stage;
  int n_errors = 0, num_checks = 0, cycles = 0;

  mms_mem_front u_dut (.clk_sys(clk_sys), .rst(rst), .req(req), .resp(resp),
    .low_voltage_power_mode(lvm), .lifecycle_secure(sec), .flash_cmd(fcmd),
    .flash_line_addr(faddr), .flash_line_rd(frd), .flash_line_data(fdat), .read_line(rline),
    .cache_hit(hit), .sram_power_en(pwr), .sram_retain_en(ret), .deep_sleep(dsl),
    .hibernate_entry(hib), .sram_block_on(s_on), .sram_contents_valid(s_val),
    .sysfn_req(sfn), .secondary_nmi(nmi), .fuse_prog(fprg), .fuse_index(fidx),
    .fuse_custom_only(fco), .fuse_bits(fuses), .boot_step_done(stp), .boot_check_ok(ck_ok),
    .user_valid(uv), .boot_stage(stage), .syscalls_enabled(sys_en),
    .debug_configured(dbg_en), .user_launched(launched), .safe_state(safe),
    .vector_base(vbase));
  mms_flash_model u_flash (.flash_line_addr(faddr), .flash_line_rd(frd),
    .flash_line_data(fdat));

  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang anywhere counts as a mismatch and still reaches the report.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
  endtask

  // One request held for one edge; the answer stands for one cycle only, so it is judged
  // at the falling edge that follows the taking edge.
  task automatic acc(input mms_master_t m, input logic [2:0] c, input logic w, input logic f,
                     input logic [31:0] a, input logic e, input mms_target_t t,
                     input logic [31:0] o);
    @(negedge clk_sys);
    req = '{1'b1, w, f, m, c, a};
    @(negedge clk_sys);
    req.valid = 1'b0;
    `CHK(resp.done, 1'b1)
    `CHK(resp.error, e)
    `CHK(resp.target, e ? MMS_T_NONE : t)
    if (!e) `CHK(resp.offset, o)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_map();
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h0000_FFFC, 1'b0, MMS_T_ROM, 32'h0000_FFFC);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h0001_0000, 1'b1, MMS_T_NONE, 32'h0);
    acc(SC, 3'h0, 1'b0, 1'b0, 32'h0801_FFFC, 1'b0, MMS_T_SRAM, 32'h0001_FFFC);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h0802_0000, 1'b1, MMS_T_NONE, 32'h0);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h1003_FFF0, 1'b0, MMS_T_AFL, 32'h0003_FFF0);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h1004_0000, 1'b1, MMS_T_NONE, 32'h0);
    acc(SC, 3'h0, 1'b0, 1'b0, 32'h1600_7FF0, 1'b0, MMS_T_SFL, 32'h0000_7FF0);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h1600_8000, 1'b1, MMS_T_NONE, 32'h0);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h2000_0000, 1'b1, MMS_T_NONE, 32'h0);
    acc(MC, 3'h0, 1'b1, 1'b0, 32'h3FFF_FFFC, 1'b1, MMS_T_NONE, 32'h0);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h4000_0000, 1'b0, MMS_T_PERIPH, 32'h0);
    acc(MC, 3'h0, 1'b0, 1'b1, 32'h5FFF_FFFC, 1'b1, MMS_T_NONE, 32'h0);
    acc(MC, 3'h0, 1'b0, 1'b1, 32'h9FFF_FFFC, 1'b0, MMS_T_EXT, 32'h3FFF_FFFC);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'hA000_0000, 1'b1, MMS_T_NONE, 32'h0);
  endtask

  task automatic t_exec();
    acc(SC, 3'h0, 1'b0, 1'b1, 32'h0000_0100, 1'b0, MMS_T_ROM, 32'h0000_0100);
    acc(SC, 3'h1, 1'b0, 1'b1, 32'h0000_0100, 1'b1, MMS_T_NONE, 32'h0);
    acc(MC, 3'h0, 1'b0, 1'b1, 32'h0000_0000, 1'b1, MMS_T_NONE, 32'h0);
    acc(SC, 3'h0, 1'b1, 1'b0, 32'h0000_0100, 1'b1, MMS_T_NONE, 32'h0);
    `CHK(vbase, VECTOR_BASE)
  endtask

  task automatic t_flash();
    acc(MC, 3'h0, 1'b1, 1'b0, 32'h1000_0234, 1'b0, MMS_T_AFL, 32'h0000_0234);
    `CHK(fcmd, {1'b1, 1'b0, 32'h0000_0200})
    lvm = 1'b1;
    acc(MC, 3'h0, 1'b1, 1'b0, 32'h1000_0400, 1'b1, MMS_T_NONE, 32'h0);
    `CHK(fcmd.row_write, 1'b0)
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h1002_0010, 1'b0, MMS_T_AFL, 32'h0002_0010);
    lvm = 1'b0;
    acc(SC, 3'h0, 1'b1, 1'b0, 32'h1600_7E10, 1'b0, MMS_T_SFL, 32'h0000_7E10);
    `CHK(fcmd, {1'b1, 1'b1, 32'h0000_7E00})
    sec = 1'b1;
    acc(SC, 3'h0, 1'b1, 1'b0, 32'h1600_0000, 1'b1, MMS_T_NONE, 32'h0);
    `CHK(fcmd.row_write, 1'b0)
    sec = 1'b0;
  endtask

  // A read is a miss or a hit; a miss fetches a 16-byte line one edge later.
  task automatic rd_line(input mms_master_t m, input logic miss, input logic [1:0] h);
    acc(m, 3'h0, 1'b0, 1'b0, 32'h1000_0128, 1'b0, MMS_T_AFL, 32'h0000_0128);
    `CHK(frd, miss)
    `CHK(hit, h)
    if (miss) `CHK(faddr, 32'h0000_0120)
    tick();
    if (miss) `CHK(rline, {4{32'h0000_0120}})
  endtask

  task automatic t_cache();
    rd_line(MC, 1'b1, 2'b00);
    rd_line(MC, 1'b0, 2'b01);
    rd_line(MMS_DMA, 1'b1, 2'b00);
    rd_line(SC, 1'b1, 2'b00);
    rd_line(SC, 1'b0, 2'b10);
    acc(MC, 3'h0, 1'b1, 1'b0, 32'h1000_1000, 1'b0, MMS_T_AFL, 32'h0000_1000);
    rd_line(MC, 1'b1, 2'b00);
  endtask

  task automatic t_sram();
    @(negedge clk_sys);
    pwr = 4'hE;
    repeat (2) tick();
    `CHK(s_on, 4'hE)
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h0800_0000, 1'b1, MMS_T_NONE, 32'h0);
    acc(MC, 3'h0, 1'b0, 1'b0, 32'h0800_8004, 1'b0, MMS_T_SRAM, 32'h0000_8004);
    @(negedge clk_sys);
    ret = 4'h3;
    dsl = 1'b1;
    repeat (2) tick();
    `CHK(s_val & 4'hC, 4'h0)
    @(negedge clk_sys);
    dsl = 1'b0;
    hib = 1'b1;
    @(negedge clk_sys);
    hib = 1'b0;
    `CHK(s_val, 4'h0)
    pwr = 4'hF;
    ret = 4'hF;
  endtask

  task automatic t_nmi();
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys);
      sfn = 3'h1 << i;
      tick();
      `CHK(nmi, 1'b1)
      @(negedge clk_sys);
      sfn = 3'h0;
      tick();
      `CHK(nmi, 1'b0)
    end
  endtask

  task automatic fprog(input logic [9:0] idx, input logic co, input logic take);
    @(negedge clk_sys);
    fprg = 1'b1;
    fidx = idx;
    fco = co;
    @(negedge clk_sys);
    fprg = 1'b0;
    if (take) fexp[idx] = 1'b1;
    `CHK(fuses, fexp)
  endtask

  task automatic t_fuse();
    fprog(10'h1FF, 1'b1, 1'b0);
    fprog(10'h200, 1'b1, 1'b1);
    fprog(10'h000, 1'b0, 1'b1);
    fprog(10'h3FF, 1'b0, 1'b1);
    fprog(10'h200, 1'b0, 1'b1);
  endtask

  task automatic t_boot(input logic ck, input logic u);
    ck_ok = ck;
    uv = u;
    do_reset();
    `CHK(stage, MMS_B_CHECK_FBOOT)
    for (int i = 1; i <= 7; i++) begin
      @(negedge clk_sys);
      stp = 1'b1;
      @(negedge clk_sys);
      stp = 1'b0;
      if (!ck) break;
      `CHK(stage, i < 7 ? mms_boot_t'(i) : (u ? MMS_B_USER : MMS_B_SAFE))
    end
    `CHK(stage, (ck && u) ? MMS_B_USER : MMS_B_SAFE)
    `CHK(sys_en, ck)
    `CHK(dbg_en, ck)
    `CHK(launched, ck && u)
    `CHK(safe, !(ck && u))
  endtask

  initial begin
    do_reset();
    t_map();
    t_exec();
    t_flash();
    t_cache();
    t_sram();
    t_nmi();
    t_fuse();
    t_boot(1'b1, 1'b1);
    t_boot(1'b1, 1'b0);
    t_boot(1'b0, 1'b1);
    wrap_up();
  end
endmodule
